// ---- verilog/clk_cfg_pkg.sv ----
package clk_cfg_pkg;

    // ********************************************************
    // Register offsets on the control port
    // ********************************************************
    localparam logic [7:0] FRAC_LOW_ADDR = 8'h37;
    localparam logic [7:0] INT_LOW_ADDR  = 8'h38;
    localparam logic [7:0] N_PDM_ADDR    = 8'h39;
    localparam logic [7:0] M_ADDR        = 8'h3a;
    localparam logic [7:0] MOD_BCLK_ADDR = 8'h3b;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] FRAC_LOW_RST = 8'h00;
    localparam logic [7:0] INT_LOW_RST  = 8'h08;
    localparam logic [7:0] N_PDM_RST    = 8'h20;
    localparam logic [7:0] M_RST        = 8'h04;
    localparam logic [7:0] MOD_BCLK_RST = 8'h00;

    // Bit 0 of the modulator register is read only
    localparam logic [7:0] MOD_BCLK_WMASK = 8'hfe;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int N_MSB        = 7;
    localparam int N_LSB        = 5;
    localparam int PDM_MSB      = 4;
    localparam int PDM_LSB      = 2;
    localparam int M_MSB        = 7;
    localparam int M_LSB        = 2;
    localparam int MOD_MSB      = 5;
    localparam int MOD_LSB      = 4;
    localparam int PRI_HIGH_BIT = 2;
    localparam int SEC_HIGH_BIT = 1;
    localparam int PREV_INT_BIT = 7;
    localparam int PREV_FRAC_MSB = 5;

    // ********************************************************
    // Widths and code limits
    // ********************************************************
    localparam int FRAC_W = 14;
    localparam int INT_W  = 9;
    localparam int N_W    = 3;
    localparam int M_W    = 6;
    localparam int PDM_W  = 3;
    localparam int MOD_W  = 2;

    localparam logic [13:0] FRAC_MAX     = 14'h270f;
    localparam logic [8:0]  INT_RESERVED = 9'h000;
    localparam logic [2:0]  PDM_MAX      = 3'h4;
    localparam logic [1:0]  MOD_RESERVED = 2'h3;

endpackage : clk_cfg_pkg

// ---- verilog/ratio_decode.sv ----
`timescale 1ns/1ps

// Code to ratio: code zero means two to the width, others equal the code
module ratio_decode #(
    parameter int W = 3
) (
    input  wire logic [W-1:0] code,
    output logic      [W:0]   ratio
);

    // ********************************************************
    // Decode
    // ********************************************************
    always_comb begin
        if (code == '0) begin
            ratio = {1'b1, {W{1'b0}}};
        end else begin
            ratio = {1'b0, code};
        end
    end

endmodule : ratio_decode

// ---- verilog/clock_ratio_config.sv ----
`timescale 1ns/1ps

module clock_ratio_config (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  prev_clock_config,
    input  wire logic        auto_detect_en,
    input  wire logic [13:0] auto_fraction,
    input  wire logic [8:0]  auto_integer,
    input  wire logic [3:0]  auto_n_ratio,
    input  wire logic [6:0]  auto_m_ratio,
    input  wire logic [4:0]  auto_pdm_ratio,
    input  wire logic [2:0]  auto_modulator_ratio,
    output logic      [13:0] pll_fraction,
    output logic      [8:0]  pll_integer,
    output logic      [3:0]  n_ratio,
    output logic      [4:0]  pulse_density_ratio,
    output logic      [6:0]  m_ratio,
    output logic      [2:0]  modulator_clock_ratio,
    output logic             primary_bitclock_ratio_high,
    output logic             secondary_bitclock_ratio_high,
    output logic             config_fault
);

    // ********************************************************
    // Register file
    // ********************************************************
    logic [7:0]  frac_low_q, frac_low_d;
    logic [7:0]  int_low_q,  int_low_d;
    logic [7:0]  n_pdm_q,    n_pdm_d;
    logic [7:0]  m_reg_q,    m_reg_d;
    logic [7:0]  mod_bclk_q, mod_bclk_d;
    logic [7:0]  rdata_q,    rdata_d;

    // Next register values from control port writes
    always_comb begin
        frac_low_d = frac_low_q;
        int_low_d  = int_low_q;
        n_pdm_d    = n_pdm_q;
        m_reg_d    = m_reg_q;
        mod_bclk_d = mod_bclk_q;
        if (reg_write) begin
            unique case (reg_addr)
                clk_cfg_pkg::FRAC_LOW_ADDR: frac_low_d = reg_wdata;
                clk_cfg_pkg::INT_LOW_ADDR:  int_low_d  = reg_wdata;
                clk_cfg_pkg::N_PDM_ADDR:    n_pdm_d    = reg_wdata;
                clk_cfg_pkg::M_ADDR:        m_reg_d    = reg_wdata;
                clk_cfg_pkg::MOD_BCLK_ADDR: mod_bclk_d = reg_wdata & clk_cfg_pkg::MOD_BCLK_WMASK;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero, one cycle latency
    always_comb begin
        unique case (reg_addr)
            clk_cfg_pkg::FRAC_LOW_ADDR: rdata_d = frac_low_q;
            clk_cfg_pkg::INT_LOW_ADDR:  rdata_d = int_low_q;
            clk_cfg_pkg::N_PDM_ADDR:    rdata_d = n_pdm_q;
            clk_cfg_pkg::M_ADDR:        rdata_d = m_reg_q;
            clk_cfg_pkg::MOD_BCLK_ADDR: rdata_d = mod_bclk_q;
            default:                    rdata_d = 8'h00;
        endcase
    end

    // Register storage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            frac_low_q <= clk_cfg_pkg::FRAC_LOW_RST;
            int_low_q  <= clk_cfg_pkg::INT_LOW_RST;
            n_pdm_q    <= clk_cfg_pkg::N_PDM_RST;
            m_reg_q    <= clk_cfg_pkg::M_RST;
            mod_bclk_q <= clk_cfg_pkg::MOD_BCLK_RST;
            rdata_q    <= 8'h00;
        end else begin
            frac_low_q <= frac_low_d;
            int_low_q  <= int_low_d;
            n_pdm_q    <= n_pdm_d;
            m_reg_q    <= m_reg_d;
            mod_bclk_q <= mod_bclk_d;
            rdata_q    <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ********************************************************
    // Field joining and decoding
    // ********************************************************
    logic [13:0] man_fraction;
    logic [8:0]  man_integer;
    logic [2:0]  n_code;
    logic [5:0]  m_code;
    logic [2:0]  pdm_code;
    logic [1:0]  mod_code;
    logic [3:0]  man_n;
    logic [6:0]  man_m;
    logic [4:0]  man_pdm;
    logic [2:0]  man_mod;

    // High fields on top, stored byte at bottom
    assign man_fraction = {prev_clock_config[clk_cfg_pkg::PREV_FRAC_MSB:0],
                           frac_low_q};
    assign man_integer  = {prev_clock_config[clk_cfg_pkg::PREV_INT_BIT],
                           int_low_q};
    assign n_code   = n_pdm_q[clk_cfg_pkg::N_MSB:clk_cfg_pkg::N_LSB];
    assign pdm_code = n_pdm_q[clk_cfg_pkg::PDM_MSB:clk_cfg_pkg::PDM_LSB];
    assign m_code   = m_reg_q[clk_cfg_pkg::M_MSB:clk_cfg_pkg::M_LSB];
    assign mod_code = mod_bclk_q[clk_cfg_pkg::MOD_MSB:clk_cfg_pkg::MOD_LSB];

    // Zero code selects the top ratio
    ratio_decode #(.W(clk_cfg_pkg::N_W)) u_n_decode (
        .code  (n_code),
        .ratio (man_n)
    );

    ratio_decode #(.W(clk_cfg_pkg::M_W)) u_m_decode (
        .code  (m_code),
        .ratio (man_m)
    );

    // Power of two ratios; reserved codes saturate at the top ratio
    always_comb begin
        if (pdm_code > clk_cfg_pkg::PDM_MAX) begin
            man_pdm = 5'h10;
        end else begin
            man_pdm = 5'(5'h01 << pdm_code);
        end
        if (mod_code == clk_cfg_pkg::MOD_RESERVED) begin
            man_mod = 3'h4;
        end else begin
            man_mod = 3'(3'h1 << mod_code);
        end
    end

    // ********************************************************
    // Effective ratios with auto detection override
    // ********************************************************
    logic [13:0] fraction_q, fraction_d;
    logic [8:0]  integer_q,  integer_d;
    logic [3:0]  n_q,        n_d;
    logic [6:0]  m_q,        m_d;
    logic [4:0]  pdm_q,      pdm_d;
    logic [2:0]  mod_q,      mod_d;
    logic        pri_q,      pri_d;
    logic        sec_q,      sec_d;
    logic        fault_q,    fault_d;

    // Select stored or detected ratios, flag reserved codes
    always_comb begin
        pri_d = mod_bclk_q[clk_cfg_pkg::PRI_HIGH_BIT];
        sec_d = mod_bclk_q[clk_cfg_pkg::SEC_HIGH_BIT];
        if (auto_detect_en) begin
            fraction_d = auto_fraction;
            integer_d  = auto_integer;
            n_d        = auto_n_ratio;
            m_d        = auto_m_ratio;
            pdm_d      = auto_pdm_ratio;
            mod_d      = auto_modulator_ratio;
            fault_d    = 1'b0;
        end else begin
            fraction_d = man_fraction;
            integer_d  = man_integer;
            n_d        = man_n;
            m_d        = man_m;
            pdm_d      = man_pdm;
            mod_d      = man_mod;
            fault_d    = (man_fraction > clk_cfg_pkg::FRAC_MAX)
                       | (man_integer == clk_cfg_pkg::INT_RESERVED)
                       | (pdm_code > clk_cfg_pkg::PDM_MAX)
                       | (mod_code == clk_cfg_pkg::MOD_RESERVED);
        end
    end

    // Output registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fraction_q <= 14'h0000;
            integer_q  <= 9'h008;
            n_q        <= 4'h1;
            m_q        <= 7'h01;
            pdm_q      <= 5'h01;
            mod_q      <= 3'h1;
            pri_q      <= 1'b0;
            sec_q      <= 1'b0;
            fault_q    <= 1'b0;
        end else begin
            fraction_q <= fraction_d;
            integer_q  <= integer_d;
            n_q        <= n_d;
            m_q        <= m_d;
            pdm_q      <= pdm_d;
            mod_q      <= mod_d;
            pri_q      <= pri_d;
            sec_q      <= sec_d;
            fault_q    <= fault_d;
        end
    end

    assign pll_fraction                  = fraction_q;
    assign pll_integer                   = integer_q;
    assign n_ratio                       = n_q;
    assign pulse_density_ratio           = pdm_q;
    assign m_ratio                       = m_q;
    assign modulator_clock_ratio         = mod_q;
    assign primary_bitclock_ratio_high   = pri_q;
    assign secondary_bitclock_ratio_high = sec_q;
    assign config_fault                  = fault_q;

    // ********************************************************
    // Assertions
    // ********************************************************
    frac_join_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !auto_detect_en |=> pll_fraction ==
            {$past(prev_clock_config[5:0]), $past(frac_low_q)})
        else $error("fraction multiplier not joined from high bits and byte");

    int_join_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_write && reg_addr == 8'h38 && !auto_detect_en) ##1 !auto_detect_en
            |=> pll_integer == {$past(prev_clock_config[7]), $past(reg_wdata, 2)})
        else $error("integer multiplier does not follow written byte");

    n_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && n_pdm_q[7:5] == 3'h0) |=> n_ratio == 4'h8)
        else $error("n code zero does not give ratio eight");

    m_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && m_reg_q[7:2] != 6'h00) |=> m_ratio == {1'b0, $past(m_reg_q[7:2])})
        else $error("m ratio differs from nonzero code");

    pdm_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && n_pdm_q[4:2] == 3'h3) |=> pulse_density_ratio == 5'h08)
        else $error("pdm code three does not give ratio eight");

    mod_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && mod_bclk_q[5:4] == 2'h3)
            |=> config_fault && modulator_clock_ratio == 3'h4)
        else $error("reserved modulator code not flagged");

    frac_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && man_fraction == 14'h2710) |=> config_fault)
        else $error("reserved fraction code not flagged");

    int_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && man_integer == 9'h000) |=> config_fault && pll_integer == 9'h000)
        else $error("integer code zero not flagged");

    bclk_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_write && reg_addr == 8'h3b) |-> ##2 primary_bitclock_ratio_high == $past(reg_wdata[2], 2)
            && secondary_bitclock_ratio_high == $past(reg_wdata[1], 2))
        else $error("bit-clock divider top bits do not follow write");

    auto_override_a: assert property (@(posedge mclk) disable iff (!rst_n)
        auto_detect_en |=> !config_fault && m_ratio == $past(auto_m_ratio)
            && pll_integer == $past(auto_integer))
        else $error("auto detection did not override stored ratios");

    n_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && n_pdm_q[7:5] != 3'h0)
            |=> n_ratio == {1'b0, $past(n_pdm_q[7:5])})
        else $error("n ratio differs from nonzero code");

    m_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && m_reg_q[7:2] == 6'h00) |=> m_ratio == 7'h40)
        else $error("m code zero does not give ratio sixty-four");

    pdm_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && n_pdm_q[4:2] > 3'h4)
            |=> config_fault && pulse_density_ratio == 5'h10)
        else $error("reserved pdm code not flagged");

    mod_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && mod_bclk_q[5:4] == 2'h2) |=> modulator_clock_ratio == 3'h4)
        else $error("modulator code two does not give ratio four");

    int_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !auto_detect_en |=> pll_integer[8] == $past(prev_clock_config[7])
            && pll_integer[7:0] == $past(int_low_q))
        else $error("integer high bit not on top of stored byte");

    fault_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!auto_detect_en && man_fraction <= 14'h270f && man_integer != 9'h000
            && n_pdm_q[4:2] <= 3'h4 && mod_bclk_q[5:4] != 2'h3)
            |=> !config_fault)
        else $error("fault raised for legal codes");

    auto_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
        auto_detect_en |=> pll_fraction == $past(auto_fraction)
            && n_ratio == $past(auto_n_ratio) && pulse_density_ratio == $past(auto_pdm_ratio)
            && modulator_clock_ratio == $past(auto_modulator_ratio))
        else $error("auto ratios not passed through");

endmodule : clock_ratio_config

// ---- test/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;

    // ********************************************************
    // Signals and bench state
    // ********************************************************
    logic        mclk;
    logic        rst_n;
    logic        reg_write;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  prev_clock_config;
    logic        auto_detect_en;
    logic [13:0] auto_fraction;
    logic [8:0]  auto_integer;
    logic [3:0]  auto_n_ratio;
    logic [6:0]  auto_m_ratio;
    logic [4:0]  auto_pdm_ratio;
    logic [2:0]  auto_modulator_ratio;
    logic [13:0] pll_fraction;
    logic [8:0]  pll_integer;
    logic [3:0]  n_ratio;
    logic [4:0]  pulse_density_ratio;
    logic [6:0]  m_ratio;
    logic [2:0]  modulator_clock_ratio;
    logic        primary_bitclock_ratio_high;
    logic        secondary_bitclock_ratio_high;
    logic        config_fault;
    int          err_count;
    int          cmp_count;
    integer      seed;
    logic [7:0]  regs_m [0:4];

    clock_ratio_config i_dut (
        .mclk(mclk), .rst_n(rst_n), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .prev_clock_config(prev_clock_config),
        .auto_detect_en(auto_detect_en), .auto_fraction(auto_fraction),
        .auto_integer(auto_integer), .auto_n_ratio(auto_n_ratio),
        .auto_m_ratio(auto_m_ratio), .auto_pdm_ratio(auto_pdm_ratio),
        .auto_modulator_ratio(auto_modulator_ratio), .pll_fraction(pll_fraction),
        .pll_integer(pll_integer), .n_ratio(n_ratio),
        .pulse_density_ratio(pulse_density_ratio), .m_ratio(m_ratio),
        .modulator_clock_ratio(modulator_clock_ratio),
        .primary_bitclock_ratio_high(primary_bitclock_ratio_high),
        .secondary_bitclock_ratio_high(secondary_bitclock_ratio_high),
        .config_fault(config_fault)
    );

    // ********************************************************
    // Helper tasks
    // ********************************************************
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Model of the stored registers after reset
    task automatic model_reset;
        regs_m[0] = clk_cfg_pkg::FRAC_LOW_RST;
        regs_m[1] = clk_cfg_pkg::INT_LOW_RST;
        regs_m[2] = clk_cfg_pkg::N_PDM_RST;
        regs_m[3] = clk_cfg_pkg::M_RST;
        regs_m[4] = clk_cfg_pkg::MOD_BCLK_RST;
    endtask : model_reset

    // One write cycle, model updated alongside
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
        if (a >= 8'h37 && a <= 8'h3b)
            regs_m[3'(a - 8'h37)] = (a == 8'h3b) ? (d & clk_cfg_pkg::MOD_BCLK_WMASK) : d;
    endtask : wr

    // Address in one cycle, data after the next edge
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a >= 8'h37 && a <= 8'h3b) ? regs_m[3'(a - 8'h37)] : 8'h00;
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1;
        check(reg_rdata, e, "read data");
    endtask : rd

    // Read every mapped place
    task automatic rd_all;
        for (int i = 0; i < 5; i++) begin
            rd(8'(8'h37 + i));
        end
    endtask : rd_all

    // Ratio outputs two edges after the last change
    task automatic chk_out;
        logic [2:0] n_c;
        logic [2:0] p_c;
        logic [5:0] m_c;
        logic [1:0] md_c;
        logic       f_c;
        repeat (2) @(posedge mclk);
        #1;
        n_c  = regs_m[2][7:5];
        p_c  = regs_m[2][4:2];
        m_c  = regs_m[3][7:2];
        md_c = regs_m[4][5:4];
        f_c  = (p_c > 3'h4) || (md_c == 2'h3)
            || ({prev_clock_config[5:0], regs_m[0]} > clk_cfg_pkg::FRAC_MAX)
            || ({prev_clock_config[7], regs_m[1]} == 9'h000);
        if (auto_detect_en) begin
            check(pll_fraction, auto_fraction, "auto fraction");
            check(pll_integer, auto_integer, "auto integer");
            check(n_ratio, auto_n_ratio, "auto n");
            check(pulse_density_ratio, auto_pdm_ratio, "auto pdm");
            check(m_ratio, auto_m_ratio, "auto m");
            check(modulator_clock_ratio, auto_modulator_ratio, "auto mod");
            check(config_fault, 1'b0, "auto fault");
        end else begin
            check(pll_fraction, {prev_clock_config[5:0], regs_m[0]}, "fraction");
            check(pll_integer, {prev_clock_config[7], regs_m[1]}, "integer");
            check(n_ratio, (n_c == 3'h0) ? 4'h8 : {1'b0, n_c}, "n ratio");
            check(pulse_density_ratio, (p_c > 3'h4) ? 5'h10 : 5'h01 << p_c, "pdm");
            check(m_ratio, (m_c == 6'h00) ? 7'h40 : {1'b0, m_c}, "m ratio");
            check(modulator_clock_ratio, (md_c == 2'h3) ? 3'h4 : 3'h1 << md_c, "mod");
            check(config_fault, f_c, "fault");
            check(primary_bitclock_ratio_high, regs_m[4][2], "primary high");
            check(secondary_bitclock_ratio_high, regs_m[4][1], "secondary high");
        end
    endtask : chk_out

    // Verdict and end of run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // ********************************************************
    // Clock and run limit
    // ********************************************************
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        repeat (50000) @(posedge mclk);
        err_count++;
        $display("ERROR %0t run limit reached", $time);
        final_report();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        seed = 51598;
        err_count = 0;
        cmp_count = 0;
        {rst_n, reg_write, reg_addr, reg_wdata, prev_clock_config} = '0;
        {auto_detect_en, auto_fraction, auto_integer, auto_n_ratio} = '0;
        {auto_m_ratio, auto_pdm_ratio, auto_modulator_ratio} = '0;
        model_reset();
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd_all();
        chk_out();
        // Boundaries: all ones, largest fraction, all zeros
        @(posedge mclk);
        prev_clock_config <= 8'ha7;
        // Reserved bits keep their reset value
        wr(8'h37, 8'hff);
        wr(8'h38, 8'hff);
        wr(8'h39, 8'hfc);
        wr(8'h3a, 8'hfc);
        wr(8'h3b, 8'h36);
        rd_all();
        wr(8'h37, 8'h0f);
        chk_out();
        for (int i = 0; i < 5; i++) wr(8'(8'h37 + i), 8'h00);
        chk_out();
        // First reserved fraction, then integer code zero
        wr(8'h37, 8'h10);
        chk_out();
        @(posedge mclk);
        prev_clock_config <= 8'h00;
        chk_out();
        wr(8'h38, 8'h08);
        // Every n and pdm code, every modulator code
        for (int i = 0; i < 8; i++) begin
            wr(8'h39, {3'(i), 3'(i), 2'b00});
            chk_out();
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h3b, {2'b00, 2'(i), 1'b0, 3'(i << 1)});
            chk_out();
        end
        // Unmapped places are ignored and read zero
        wr(8'h36, 8'h5a);
        wr(8'h3c, 8'ha5);
        rd(8'h36);
        rd(8'h3c);
        rd_all();
        // Random legal traffic with auto detection toggling
        for (int k = 0; k < 300; k++) begin
            a = 8'(8'h37 + (($random(seed) & 32'h7fff_ffff) % 5));
            d = 8'($random(seed));
            if (a == 8'h39) d = {d[7:5], 3'((d[4:2] % 5)), 2'b00};
            if (a == 8'h3a) d = {d[7:2], 2'b00};
            if (a == 8'h3b) d = {2'b00, 2'((d[5:4] % 3)), 1'b0, d[2:1], 1'b0};
            wr(a, d);
            @(posedge mclk);
            prev_clock_config <= {2'($random(seed)), 6'(($random(seed) & 32'hffff) % 39)};
            auto_detect_en <= 1'($random(seed));
            {auto_fraction, auto_integer, auto_n_ratio} <= 27'($random(seed));
            {auto_m_ratio, auto_pdm_ratio, auto_modulator_ratio} <= 15'($random(seed));
            if (regs_m[1] == 8'h00) wr(8'h38, 8'h01);
            chk_out();
            rd(a);
        end
        // Reset in mid-run restores every register
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        auto_detect_en <= 1'b0;
        model_reset();
        rd_all();
        chk_out();
        final_report();
    end

endmodule : tb_top
